// >>> logic/rscl_top.sv
// Reset source collection, system reset generation and reset cause flags.
//
// The address map and the plain strobed port were left to the implementer.
`timescale 1ns/1ps

module rscl_top
    import rscl_pkg::*;
#(
    parameter bit HAS_CFG_CHECK = 1'b1
) (
    input  wire logic        CLK,
    input  wire logic        RST,
    input  wire logic        BOR_IN,
    input  wire logic        EXTERNAL_RESET_PIN_N,
    input  wire logic        SOFT_RESET_EXEC,
    input  wire logic        WDT_TIMEOUT,
    input  wire logic        CPU_SLEEP,
    input  wire logic        CPU_IDLE,
    input  wire logic        SLEEP_EXEC,
    input  wire logic        IDLE_EXEC,
    input  wire logic        WDT_CLEAR_EXEC,
    input  wire logic        TRAP_NEW,
    input  wire logic [3:0]  TRAP_NEW_LVL,
    input  wire logic        TRAP_ACTIVE,
    input  wire logic [3:0]  TRAP_ACTIVE_LVL,
    input  wire logic [15:0] PPS_REG,
    input  wire logic [15:0] PPS_SHADOW,
    input  wire logic        PPS_WRITE_OK,
    input  wire logic        OPCODE_EXEC,
    input  wire logic [23:0] OPCODE_WORD,
    input  wire logic        PTR_USE,
    input  wire logic [3:0]  PTR_REG,
    input  wire logic        WREG_WRITE,
    input  wire logic [3:0]  WREG_IDX,
    input  wire logic        PFC_EVENT,
    input  wire logic        VFC_EVENT,
    input  wire logic        FLOW_RESTRICTED,
    input  wire logic [1:0]  REG_ADDR,
    input  wire logic [15:0] REG_WDATA,
    input  wire logic        REG_WR,
    input  wire logic        REG_RD,
    output logic      [15:0] REG_RDATA,
    output logic             SYSTEM_RESET,
    output logic             WDT_WAKE,
    output logic             KEEP_CLOCK,
    output logic             FETCH_VECTOR,
    output logic      [14:0] WREG_INIT
);

    logic [15:0] flags_r;
    logic [15:0] flags_nxt;
    logic        ext_s1_r;
    logic        ext_s2_r;
    logic [7:0]  ext_cnt_r;
    logic [7:0]  ext_min_r;
    logic        ext_rst_r;
    logic        cold_r;
    logic        bor_seen_r;
    logic        warm_r;
    logic [14:0] winit_r;
    logic [15:0] rdata_r;
    rscl_state_t state_r;
    rscl_state_t state_nxt;

    // Hard trap level test shared by both trap inputs.
    function automatic logic is_hard(input logic [3:0] lvl);
        is_hard = (lvl >= RSCL_HARD_LO) && (lvl <= RSCL_HARD_HI);
    endfunction

    wire ext_low     = ~ext_s2_r;
    wire ext_expired = (ext_cnt_r >= ext_min_r);
    wire ext_event   = ext_low && ext_expired && !ext_rst_r;
    wire soft_event  = SOFT_RESET_EXEC && (state_r == RSCL_RUN);
    wire wdt_power   = CPU_SLEEP || CPU_IDLE;
    wire wdt_reset   = WDT_TIMEOUT && !wdt_power;
    wire wdt_wake    = WDT_TIMEOUT && wdt_power;
    wire trap_event  = TRAP_NEW && TRAP_ACTIVE
                     && is_hard(TRAP_NEW_LVL)
                     && is_hard(TRAP_ACTIVE_LVL)
                     && (TRAP_NEW_LVL < TRAP_ACTIVE_LVL);
    wire cfg_event   = HAS_CFG_CHECK && !PPS_WRITE_OK
                     && (PPS_REG != PPS_SHADOW);
    wire ill_op      = OPCODE_EXEC
                     && (OPCODE_WORD[23:16] == RSCL_ILLEGAL_OP);
    wire ptr_uninit  = PTR_USE && (PTR_REG != 4'hf)
                     && !winit_r[PTR_REG[3:0] == 4'hf ? 0 : PTR_REG];
    wire sec_event   = (PFC_EVENT || VFC_EVENT) && FLOW_RESTRICTED;
    wire ill_event   = ill_op || ptr_uninit || sec_event;
    wire any_warm    = ext_event || soft_event || wdt_reset
                     || trap_event || cfg_event || ill_event;
    wire wr_flags    = REG_WR && (REG_ADDR == RSCL_ADDR_FLAGS);
    wire wr_ctrl     = REG_WR && (REG_ADDR == RSCL_ADDR_CTRL);

    // External pin: two-stage synchroniser then a low-time counter.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            ext_s1_r  <= 1'b1;
            ext_s2_r  <= 1'b1;
            ext_cnt_r <= 8'h00;
            ext_rst_r <= 1'b0;
        end else begin
            ext_s1_r  <= EXTERNAL_RESET_PIN_N;
            ext_s2_r  <= ext_s1_r;
            ext_cnt_r <= ext_low ? (ext_expired ? ext_cnt_r
                                                : ext_cnt_r + 8'h01)
                                 : 8'h00;
            ext_rst_r <= ext_low && ext_expired;
        end
    end

    // Filter length is software-tunable but never below one cycle.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            ext_min_r <= RSCL_EXT_MIN_DEF;
        end else if (wr_ctrl) begin
            ext_min_r <= (REG_WDATA[7:0] == 8'h00) ? 8'h01 : REG_WDATA[7:0];
        end
    end

    // Cold reset tracking: RST is the power-on reset, BOR_IN the brown-out.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            cold_r     <= 1'b1;
            bor_seen_r <= 1'b0;
        end else begin
            cold_r     <= 1'b0;
            bor_seen_r <= BOR_IN;
        end
    end

    // Flag update: events win over a same-cycle software write.
    always_comb begin
        flags_nxt = flags_r;
        if (wr_flags) begin
            flags_nxt = REG_WDATA & RSCL_FLAGS_IMPL;
        end
        if (bor_seen_r) begin
            flags_nxt = (flags_nxt & RSCL_BOR_KEEP)
                      | (16'h0001 << RSCL_BIT_BOR);
        end
        if (SLEEP_EXEC || IDLE_EXEC || WDT_CLEAR_EXEC) begin
            flags_nxt[RSCL_BIT_WATCHDOG_TIMEOUT_FLAG] = 1'b0;
        end
        if (SLEEP_EXEC) begin
            flags_nxt[RSCL_BIT_SLEEP] = 1'b1;
        end
        if (IDLE_EXEC) begin
            flags_nxt[RSCL_BIT_IDLE] = 1'b1;
        end
        // Every source is checked independently so coincident causes stack.
        if (ext_event) begin
            flags_nxt[RSCL_BIT_EXT] = 1'b1;
        end
        if (soft_event) begin
            flags_nxt[RSCL_BIT_SOFT] = 1'b1;
        end
        if (WDT_TIMEOUT) begin
            flags_nxt[RSCL_BIT_WATCHDOG_TIMEOUT_FLAG] = 1'b1;
        end
        if (trap_event) begin
            flags_nxt[RSCL_BIT_TRAP] = 1'b1;
        end
        if (cfg_event) begin
            flags_nxt[RSCL_BIT_CM] = 1'b1;
        end
        if (ill_event) begin
            flags_nxt[RSCL_BIT_ILL] = 1'b1;
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            flags_r <= RSCL_FLAGS_POR_VAL;
        end else begin
            flags_r <= flags_nxt;
        end
    end

    // Software reset holds one cycle, then one cycle of vector fetch.
    always_comb begin
        case (state_r)
            RSCL_RUN:   state_nxt = soft_event ? RSCL_HOLD : RSCL_RUN;
            RSCL_HOLD:  state_nxt = RSCL_FETCH;
            RSCL_FETCH: state_nxt = RSCL_RUN;
            default:    state_nxt = RSCL_RUN;
        endcase
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            state_r <= RSCL_RUN;
            warm_r  <= 1'b0;
        end else begin
            state_r <= state_nxt;
            warm_r  <= ext_event || trap_event || cfg_event || ill_event
                    || (ext_low && ext_expired);
        end
    end

    // Working registers are uninitialised after every reset until written.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            winit_r <= 15'h0000;
        end else if (SYSTEM_RESET) begin
            winit_r <= 15'h0000;
        end else if (WREG_WRITE && (WREG_IDX != 4'hf)) begin
            winit_r[WREG_IDX] <= 1'b1;
        end
    end

    wire [15:0] src_view = {8'h00, 1'b0, ext_low, wdt_power,
                            TRAP_ACTIVE, cfg_event, 1'b0,
                            state_r};

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            rdata_r <= 16'h0000;
        end else if (REG_RD) begin
            case (REG_ADDR)
                RSCL_ADDR_FLAGS: rdata_r <= flags_r;
                RSCL_ADDR_SRC:   rdata_r <= src_view;
                RSCL_ADDR_CTRL:  rdata_r <= {8'h00, ext_min_r};
                default:         rdata_r <= 16'h0000;
            endcase
        end else begin
            rdata_r <= 16'h0000;
        end
    end

    // Watchdog path is combinational so the reset asserts without a clock.
    assign SYSTEM_RESET = RST || bor_seen_r || wdt_reset
                        || warm_r || (state_r == RSCL_HOLD);
    assign WDT_WAKE     = wdt_wake;
    assign KEEP_CLOCK   = !(cold_r || bor_seen_r);
    assign FETCH_VECTOR = (state_r == RSCL_FETCH);
    assign WREG_INIT    = winit_r;
    assign REG_RDATA    = rdata_r;

endmodule

// >>> common/rscl_pkg.sv
// Package with register map, field positions and timing of the reset cause block.
package rscl_pkg;
    localparam logic [1:0]  RSCL_ADDR_FLAGS    = 2'h0;
    localparam logic [1:0]  RSCL_ADDR_SRC      = 2'h1;
    localparam logic [1:0]  RSCL_ADDR_CTRL     = 2'h2;

    localparam int          RSCL_BIT_POR       = 0;
    localparam int          RSCL_BIT_BOR       = 1;
    localparam int          RSCL_BIT_IDLE      = 2;
    localparam int          RSCL_BIT_SLEEP     = 3;
    localparam int          RSCL_BIT_WATCHDOG_TIMEOUT_FLAG      = 4;
    localparam int          RSCL_BIT_SWDTEN    = 5;
    localparam int          RSCL_BIT_SOFT      = 6;
    localparam int          RSCL_BIT_EXT       = 7;
    localparam int          RSCL_BIT_VREGS     = 8;
    localparam int          RSCL_BIT_CM        = 9;
    localparam int          RSCL_BIT_ILL       = 14;
    localparam int          RSCL_BIT_TRAP      = 15;

    localparam logic [15:0] RSCL_FLAGS_IMPL    = 16'hc3ff;
    localparam logic [15:0] RSCL_FLAGS_POR_VAL = 16'h0003;
    localparam logic [15:0] RSCL_BOR_KEEP      = 16'h0080;

    localparam logic [7:0]  RSCL_ILLEGAL_OP    = 8'h3f;
    localparam logic [3:0]  RSCL_HARD_LO       = 4'hd;
    localparam logic [3:0]  RSCL_HARD_HI       = 4'hf;

    localparam int          RSCL_CLK_MHZ       = 100;
    localparam int          RSCL_EXT_MIN_NS    = 200;
    localparam int          RSCL_EXT_MIN_CYC   =
        (RSCL_EXT_MIN_NS * RSCL_CLK_MHZ + 999) / 1000;
    localparam logic [7:0]  RSCL_EXT_MIN_DEF   = 8'(RSCL_EXT_MIN_CYC);
    localparam logic [7:0]  RSCL_SRST_CYC      = 8'h01;

    typedef enum logic [1:0] {
        RSCL_RUN   = 2'b00,
        RSCL_HOLD  = 2'b01,
        RSCL_FETCH = 2'b10
    } rscl_state_t;
endpackage

// >>> verification/rscl_top_props.sv
// Concurrent checks on the ports of the reset cause block.
`timescale 1ns/1ps
module rscl_top_props
    import rscl_pkg::*;
(
    input wire logic        CLK,
    input wire logic        RST,
    input wire logic        WDT_TIMEOUT,
    input wire logic        CPU_SLEEP,
    input wire logic        CPU_IDLE,
    input wire logic        WDT_WAKE,
    input wire logic        SYSTEM_RESET,
    input wire logic        SOFT_RESET_EXEC,
    input wire logic        FETCH_VECTOR,
    input wire logic        KEEP_CLOCK,
    input wire logic        OPCODE_EXEC,
    input wire logic [23:0] OPCODE_WORD,
    input wire logic        TRAP_NEW,
    input wire logic [3:0]  TRAP_NEW_LVL,
    input wire logic        TRAP_ACTIVE,
    input wire logic [3:0]  TRAP_ACTIVE_LVL,
    input wire logic        PFC_EVENT,
    input wire logic        VFC_EVENT,
    input wire logic        FLOW_RESTRICTED,
    input wire logic        REG_RD,
    input wire logic [15:0] REG_RDATA
);
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    // The watchdog path is combinational, so the reset shows in its own cycle.
    AST_WDT_RESET: assert property (
        WDT_TIMEOUT && !CPU_SLEEP && !CPU_IDLE |-> SYSTEM_RESET)
        else $error("watchdog time-out gave no reset");
    AST_WDT_WAKE: assert property (
        WDT_TIMEOUT && (CPU_SLEEP || CPU_IDLE) |-> WDT_WAKE)
        else $error("watchdog time-out gave no wake");
    AST_SOFT_SEQ: assert property (
        SOFT_RESET_EXEC && !SYSTEM_RESET && !FETCH_VECTOR
        |=> SYSTEM_RESET && KEEP_CLOCK ##1 FETCH_VECTOR)
        else $error("soft reset sequence wrong");
    AST_FETCH_ONE: assert property (
        $rose(FETCH_VECTOR) |-> $past(SYSTEM_RESET) ##1 !FETCH_VECTOR)
        else $error("vector fetch pulse wrong");
    AST_ILLEGAL_OP: assert property (
        OPCODE_EXEC && OPCODE_WORD[23:16] == RSCL_ILLEGAL_OP
        |=> SYSTEM_RESET) else $error("illegal opcode gave no reset");
    AST_TRAP_CONFLICT: assert property (
        TRAP_NEW && TRAP_ACTIVE && TRAP_NEW_LVL >= RSCL_HARD_LO
        && TRAP_NEW_LVL < TRAP_ACTIVE_LVL |=> SYSTEM_RESET)
        else $error("trap conflict gave no reset");
    AST_SECURITY: assert property (
        (PFC_EVENT || VFC_EVENT) && FLOW_RESTRICTED |=> SYSTEM_RESET)
        else $error("restricted flow change gave no reset");
    AST_RDATA_IDLE: assert property (
        !$past(REG_RD) |-> REG_RDATA == 16'h0000)
        else $error("read data outside read slot");
endmodule
bind rscl_top rscl_top_props i_props (.*);

// >>> verification/rscl_far_model.sv
// External supervisor that holds the reset pin low for a set time.
`timescale 1ns/1ps
module rscl_far_model (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       go,
    input  wire logic [7:0] len,
    output logic            pin_n
);
    logic [7:0] cnt_r;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) cnt_r <= 8'h00;
        else if (go) cnt_r <= len;
        else if (cnt_r != 8'h00) cnt_r <= cnt_r - 8'h01;
    end
    // The pin has no pull-up inside; the model drives it high itself once the count reaches zero.
    assign pin_n = (cnt_r == 8'h00);
endmodule

// >>> verification/tb_rscl_top.sv
// Self-checking bench for the reset cause block.
`timescale 1ns/1ps
module tb_rscl_top
    import rscl_pkg::*;
;
    typedef struct packed {
        logic [15:0] pre;
        logic [14:0] ev;
        logic [15:0] exp;
    } rscl_row_t;
    logic CLK, RST, BOR_IN, EXTERNAL_RESET_PIN_N, SOFT_RESET_EXEC;
    logic WDT_TIMEOUT, CPU_SLEEP, CPU_IDLE, SLEEP_EXEC, IDLE_EXEC;
    logic WDT_CLEAR_EXEC, TRAP_NEW, TRAP_ACTIVE, PPS_WRITE_OK, PTR_USE;
    logic OPCODE_EXEC, WREG_WRITE, PFC_EVENT, VFC_EVENT, FLOW_RESTRICTED;
    logic REG_WR, REG_RD, SYSTEM_RESET, WDT_WAKE, KEEP_CLOCK;
    logic FETCH_VECTOR, ext_go;
    logic [3:0]  TRAP_NEW_LVL, TRAP_ACTIVE_LVL, PTR_REG, WREG_IDX;
    logic [15:0] PPS_REG, PPS_SHADOW, REG_WDATA, REG_RDATA, v;
    logic [23:0] OPCODE_WORD;
    logic [1:0]  REG_ADDR;
    logic [14:0] WREG_INIT;
    logic [7:0]  ext_len;
    int          err_total, total_checks, rst_cnt, n;
    // Each row writes a preset, fires events together, then reads flags.
    rscl_row_t rows [15] = '{
        '{16'h0000, 15'h0001, 16'h0040}, '{16'h0000, 15'h0002, 16'h0010},
        '{16'h0000, 15'h000c, 16'h8000}, '{16'h0000, 15'h0010, 16'h4000},
        '{16'h0000, 15'h0020, 16'h4000}, '{16'h0000, 15'h0140, 16'h4000},
        '{16'h0000, 15'h0180, 16'h4000}, '{16'h0000, 15'h0200, 16'h0200},
        '{16'h0010, 15'h0400, 16'h0008}, '{16'h0010, 15'h0800, 16'h0004},
        '{16'h0010, 15'h1000, 16'h0000}, '{16'hffff, 15'h2000, 16'h0082},
        '{16'h0000, 15'h4002, 16'h0010}, '{16'h0000, 15'h0011, 16'h4040},
        '{16'h0000, 15'h0040, 16'h0000}};
    rscl_top i_dut (.*);
    rscl_far_model i_far (.clk(CLK), .rst(RST), .go(ext_go), .len(ext_len),
        .pin_n(EXTERNAL_RESET_PIN_N));
    initial begin
        CLK = 1'b0;
        forever #5 CLK = ~CLK;
    end
    always @(posedge CLK) if (SYSTEM_RESET === 1'b1) rst_cnt++;
    task automatic fire(input logic [14:0] ev);
        @(posedge CLK);
        {CPU_SLEEP, BOR_IN, WDT_CLEAR_EXEC, IDLE_EXEC, SLEEP_EXEC, PPS_REG[0],
            FLOW_RESTRICTED, VFC_EVENT, PFC_EVENT, PTR_USE, OPCODE_EXEC,
            TRAP_ACTIVE, TRAP_NEW, WDT_TIMEOUT, SOFT_RESET_EXEC} <= ev;
    endtask
    task automatic wr(input logic [1:0] a, input logic [15:0] d);
        @(posedge CLK);
        REG_WR <= 1'b1;
        REG_ADDR <= a;
        REG_WDATA <= d;
        @(posedge CLK);
        REG_WR <= 1'b0;
    endtask
    task automatic rd(input logic [1:0] a, output logic [15:0] d);
        @(posedge CLK);
        REG_RD <= 1'b1;
        REG_ADDR <= a;
        @(posedge CLK);
        REG_RD <= 1'b0;
        #1 d = REG_RDATA;
    endtask
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        total_checks++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic ext(input logic [7:0] l);
        @(posedge CLK);
        ext_go <= 1'b1;
        ext_len <= l;
        @(posedge CLK);
        ext_go <= 1'b0;
        repeat (90) @(posedge CLK);
    endtask
    task report_and_stop;
        $display("checks=%0d errors=%0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        #100000;
        err_total++;
        report_and_stop();
    end
    initial begin
        {RST, REG_WR, REG_RD, ext_go, CPU_IDLE, PPS_WRITE_OK} <= 6'h20;
        {WREG_WRITE, WREG_IDX, REG_ADDR, REG_WDATA, ext_len} <= '0;
        {PPS_REG, PPS_SHADOW, TRAP_NEW_LVL, TRAP_ACTIVE_LVL} <= 40'hdf;
        {OPCODE_WORD, PTR_REG} <= {24'h3fbeef, 4'h3};
        fire(15'h0000);
        repeat (12) @(posedge CLK);
        RST <= 1'b0;
        rd(RSCL_ADDR_FLAGS, v);
        chk(v, RSCL_FLAGS_POR_VAL);
        rd(2'h3, v);
        chk(v, 16'h0000);
        n = rst_cnt;
        wr(RSCL_ADDR_FLAGS, 16'hffff);
        rd(RSCL_ADDR_FLAGS, v);
        chk(v, RSCL_FLAGS_IMPL);
        chk(16'(rst_cnt - n), 16'h0000);
        foreach (rows[i]) begin
            wr(RSCL_ADDR_FLAGS, rows[i].pre);
            fire(rows[i].ev);
            fire(15'h0000);
            repeat (4) @(posedge CLK);
            rd(RSCL_ADDR_FLAGS, v);
            chk(v, rows[i].exp);
        end
        chk({1'b0, WREG_INIT}, 16'h0000);
        @(posedge CLK);
        {WREG_WRITE, WREG_IDX} <= {1'b1, 4'h3};
        @(posedge CLK);
        WREG_WRITE <= 1'b0;
        #1 chk({1'b0, WREG_INIT}, 16'h0008);
        wr(RSCL_ADDR_FLAGS, 16'h0000);
        fire(15'h0020);
        fire(15'h0000);
        repeat (4) @(posedge CLK);
        rd(RSCL_ADDR_FLAGS, v);
        chk(v, 16'h0000);
        // A legal pin-select write must not count as a mismatch.
        @(posedge CLK);
        PPS_WRITE_OK <= 1'b1;
        fire(15'h0200);
        fire(15'h0000);
        PPS_WRITE_OK <= 1'b0;
        rd(RSCL_ADDR_FLAGS, v);
        chk(v, 16'h0000);
        // A time-out beside a clearing write must still leave its flag.
        @(posedge CLK);
        {REG_WR, REG_ADDR, REG_WDATA, WDT_TIMEOUT} <=
            {1'b1, RSCL_ADDR_FLAGS, 16'h0000, 1'b1};
        @(posedge CLK);
        {REG_WR, WDT_TIMEOUT} <= 2'b00;
        rd(RSCL_ADDR_FLAGS, v);
        chk(v, 16'h0010);
        rd(RSCL_ADDR_CTRL, v);
        chk(v, {8'h00, RSCL_EXT_MIN_DEF});
        wr(RSCL_ADDR_CTRL, 16'h0000);
        rd(RSCL_ADDR_CTRL, v);
        chk(v, 16'h0001);
        wr(RSCL_ADDR_CTRL, {8'h00, RSCL_EXT_MIN_DEF});
        wr(RSCL_ADDR_FLAGS, 16'h0000);
        n = rst_cnt;
        ext(8'h08);
        chk(16'(rst_cnt - n), 16'h0000);
        ext(8'h3c);
        chk({15'h0000, rst_cnt > n}, 16'h0001);
        rd(RSCL_ADDR_FLAGS, v);
        chk(v, 16'h0080);
        @(posedge CLK);
        RST <= 1'b1;
        @(posedge CLK);
        RST <= 1'b0;
        rd(RSCL_ADDR_FLAGS, v);
        chk(v, RSCL_FLAGS_POR_VAL);
        report_and_stop();
    end
endmodule
